//--- dv/modem_rx_timeout_config_tb_top.sv
`timescale 1ns/1ps
`include "modem_rx_defines.svh"

module modem_rx_timeout_config_tb_top
	import modem_rx_pkg::*;
;
	logic        clock, rst_b, ce, write_strobe, read_strobe, msk_mode, ook_mode;
	logic        rc_clock_pin, rx_start, sync_found, preamble_quality, carrier_sense;
	logic        symbol_tick, packet_end, rx_active, rx_timeout, rx_stay, rx_carrier_end;
	logic [7:0]  address, write_data, channel_number;
	reg_byte_t   read_data;
	logic [23:0] base_frequency, operating_frequency;
	logic [15:0] wake_event_zero;
	logic [1:0]  wake_resolution;
	logic [11:0] channel_spacing;
	logic [10:0] deviation_step;
	logic [2:0]  msk_phase_fraction;
	int          n_fail, compares, n_to, n_stay, n_cend;

	modem_rx_timeout_config u_modem_rx_timeout_config
	(
		.clock(clock), .rst_b(rst_b), .ce(ce), .address(address),
		.write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
		.read_data(read_data), .channel_number(channel_number),
		.base_frequency(base_frequency), .msk_mode(msk_mode), .ook_mode(ook_mode),
		.wake_event_zero(wake_event_zero), .wake_resolution(wake_resolution),
		.rc_clock_pin(rc_clock_pin), .rx_start(rx_start), .sync_found(sync_found),
		.preamble_quality(preamble_quality), .carrier_sense(carrier_sense),
		.symbol_tick(symbol_tick), .packet_end(packet_end),
		.channel_spacing(channel_spacing), .operating_frequency(operating_frequency),
		.deviation_step(deviation_step), .msk_phase_fraction(msk_phase_fraction),
		.rx_active(rx_active), .rx_timeout(rx_timeout), .rx_stay(rx_stay),
		.rx_carrier_end(rx_carrier_end)
	);

	always #10 clock = ~clock;

	// Pulses are counted here so that no single-cycle output is missed.
	always @(posedge clock)
	begin
		if (rx_timeout === 1'b1) n_to++;
		if (rx_stay === 1'b1) n_stay++;
		if (rx_carrier_end === 1'b1) n_cend++;
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write_data <= d;
		write_strobe <= 1'b1;
		@(posedge clock);
		write_strobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clock);
		address <= a;
		read_strobe <= 1'b1;
		@(posedge clock);
		read_strobe <= 1'b0;
		#1 chk(read_data, e);
	endtask

	task automatic start_rx();
		@(posedge clock);
		rx_start <= 1'b1;
		@(posedge clock);
		rx_start <= 1'b0;
		cyc(3);
		#1 chk(rx_active, 1'b1);
	endtask

	task automatic rc(input int n);
		@(posedge clock);
		repeat (n)
		begin
			rc_clock_pin <= 1'b1;
			cyc(6);
			rc_clock_pin <= 1'b0;
			cyc(6);
		end
	endtask

	function automatic int units(input int s, input int r, input int ev);
		int c;
		c = ev >> (3 + s);
		if (c < 1) c = 1;
		return c << (4 * r);
	endfunction

	// Runs one sync search and checks the edge on which it expires.
	task automatic search(input logic [7:0] ctrl, input logic [1:0] res, input logic [15:0] ev,
		input logic sf, input logic pq, input int e_to, input int e_stay);
		int t0;
		int s0;
		int n;
		n = (ctrl[2:0] == 3'h7) ? 20 : units(ctrl[2:0], res, ev);
		wr(`REG_RX_TIMEOUT_CTRL, ctrl);
		wake_resolution <= res;
		wake_event_zero <= ev;
		sync_found <= sf;
		preamble_quality <= pq;
		start_rx();
		t0 = n_to;
		s0 = n_stay;
		rc(n - 1);
		#1 chk(n_to + n_stay - t0 - s0, 0);
		rc(1);
		#1 chk(n_to - t0, e_to);
		chk(n_stay - s0, e_stay);
		chk(rx_active, (e_stay != 0) || (ctrl[2:0] == 3'h7));
		cyc(1);
		packet_end <= 1'b1;
		@(posedge clock);
		packet_end <= 1'b0;
		cyc(2);
		#1 chk(rx_active, 1'b0);
		$display("search %h done", ctrl);
	endtask

	task automatic end_of_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial
	begin
		cyc(90000);
		n_fail++;
		end_of_test();
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		int c0;
		clock = 1'b0;
		rst_b = 1'b0;
		ce = 1'b1;
		{write_strobe, read_strobe, msk_mode, ook_mode, rc_clock_pin, rx_start} = '0;
		{sync_found, preamble_quality, carrier_sense, symbol_tick, packet_end} = '0;
		address = 8'h00;
		write_data = 8'h00;
		channel_number = 8'h05;
		base_frequency = 24'h100000;
		wake_event_zero = 16'h0010;
		wake_resolution = 2'h0;
		{n_fail, compares, n_to, n_stay, n_cend} = '0;
		cyc(3);
		rst_b <= 1'b1;

		rd(`REG_SPACING_EXPONENT, 8'h02);
		rd(`REG_SPACING_MANTISSA, 8'hF8);
		rd(`REG_FREQ_DEVIATION, 8'h47);
		rd(`REG_RX_TIMEOUT_CTRL, 8'h07);
		rd(8'h17, 8'h00);
		$display("reset values done");

		cyc(4);
		#1 chk(channel_spacing, 12'h7E0);
		chk(operating_frequency, 24'h100000 + 2016 * 5);
		chk(deviation_step, 11'h0F0);
		wr(`REG_SPACING_MANTISSA, 8'hFF);
		wr(`REG_SPACING_EXPONENT, 8'h03);
		wr(`REG_FREQ_DEVIATION, 8'h75);
		cyc(4);
		#1 chk(channel_spacing, 12'hFF8);
		chk(operating_frequency, 24'h100000 + 4088 * 5);
		chk(deviation_step, 11'h680);
		chk(msk_phase_fraction, 3'h0);
		cyc(1);
		msk_mode <= 1'b1;
		cyc(4);
		#1 chk(msk_phase_fraction, 3'h5);
		chk(deviation_step, 11'h000);
		cyc(1);
		msk_mode <= 1'b0;
		channel_number <= 8'h00;
		wr(`REG_SPACING_EXPONENT, 8'h00);
		wr(`REG_FREQ_DEVIATION, 8'h02);
		cyc(4);
		#1 chk(channel_spacing, 12'h1FF);
		chk(operating_frequency, 24'h100000);
		chk(deviation_step, 11'h00A);
		$display("frequency done");

		wr(`REG_SPACING_EXPONENT, 8'hFF);
		wr(`REG_FREQ_DEVIATION, 8'hFF);
		wr(`REG_RX_TIMEOUT_CTRL, 8'hFF);
		wr(8'h17, 8'hFF);
		rd(`REG_SPACING_EXPONENT, 8'h03);
		rd(`REG_FREQ_DEVIATION, 8'h77);
		rd(`REG_RX_TIMEOUT_CTRL, 8'h1F);
		rd(8'h17, 8'h00);
		$display("reserved bits done");

		search(8'h00, 2'h0, 16'h0010, 1'b0, 1'b0, 1, 0);
		rd(`REG_RX_STATUS, 8'h04);
		search(8'h06, 2'h0, 16'h0600, 1'b0, 1'b0, 1, 0);
		search(8'h03, 2'h1, 16'h0040, 1'b0, 1'b0, 1, 0);
		search(8'h00, 2'h0, 16'h0004, 1'b0, 1'b0, 1, 0);
		search(8'h00, 2'h0, 16'h0010, 1'b1, 1'b0, 0, 1);
		rd(`REG_RX_STATUS, 8'h00);
		search(8'h08, 2'h0, 16'h0010, 1'b0, 1'b1, 0, 1);
		search(8'h00, 2'h0, 16'h0010, 1'b0, 1'b1, 1, 0);
		search(8'h08, 2'h0, 16'h0010, 1'b0, 1'b0, 1, 0);
		search(8'h07, 2'h0, 16'h0010, 1'b0, 1'b0, 0, 0);
		cyc(1);
		sync_found <= 1'b0;
		preamble_quality <= 1'b0;

		wr(`REG_RX_TIMEOUT_CTRL, 8'h17);
		carrier_sense <= 1'b1;
		start_rx();
		c0 = n_cend;
		cyc(1);
		carrier_sense <= 1'b0;
		cyc(3);
		#1 chk(n_cend - c0, 1);
		chk(rx_active, 1'b0);
		cyc(1);
		ook_mode <= 1'b1;
		start_rx();
		c0 = n_to;
		cyc(1);
		repeat (7)
		begin
			symbol_tick <= 1'b1;
			@(posedge clock);
			symbol_tick <= 1'b0;
			@(posedge clock);
		end
		cyc(2);
		#1 chk(n_to - c0, 0);
		chk(rx_active, 1'b1);
		cyc(1);
		symbol_tick <= 1'b1;
		@(posedge clock);
		symbol_tick <= 1'b0;
		cyc(3);
		#1 chk(n_to - c0, 1);
		chk(rx_active, 1'b0);
		$display("carrier sense done");
		end_of_test();
	end
endmodule // modem_rx_timeout_config_tb_top

//--- hw/modem_freq_calc.sv
`timescale 1ns/1ps
`include "modem_rx_defines.svh"

module modem_freq_calc
	import modem_rx_pkg::*;
#(
	parameter int BASE_W = 24
)
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic [7:0]        spacing_mantissa,
	input  wire logic [1:0]        spacing_exponent,
	input  wire logic [7:0]        channel_number,
	input  wire logic [BASE_W-1:0] base_frequency,
	input  wire logic [2:0]        deviation_exponent,
	input  wire logic [2:0]        deviation_mantissa,
	input  wire logic              msk_mode,
	output logic      [11:0]       channel_spacing,
	output logic      [BASE_W-1:0] operating_frequency,
	output logic      [10:0]       deviation_step,
	output logic      [2:0]        msk_phase_fraction
);

	logic [11:0] next_spacing;
	logic [19:0] channel_offset;
	logic [10:0] next_deviation;

	// Spacing and deviation are in units of the crystal over 2^18 and 2^17.
	always_comb
	begin
		next_spacing   = {3'h0, `SPACING_IMPLIED_ONE | {1'b0, spacing_mantissa}}
			<< spacing_exponent;
		channel_offset = {8'h00, next_spacing} * {12'h000, channel_number};
		next_deviation = {7'h00, `DEVIATION_IMPLIED_ONE | {1'b0, deviation_mantissa}}
			<< deviation_exponent;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			channel_spacing     <= 12'h000;
			operating_frequency <= '0;
			deviation_step      <= 11'h000;
			msk_phase_fraction  <= 3'h0;
		end
		else if (ce)
		begin
			channel_spacing     <= next_spacing;
			operating_frequency <= base_frequency
				+ {{(BASE_W-20){1'b0}}, channel_offset};
			// In MSK the mantissa is a phase-change fraction, not a deviation.
			deviation_step      <= msk_mode ? 11'h000 : next_deviation;
			msk_phase_fraction  <= msk_mode ? deviation_mantissa : 3'h0;
		end
	end

	spacing_formula_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && spacing_exponent == 2'h0 |=> channel_spacing == {4'h1, $past(spacing_mantissa)})
		else $error("channel spacing does not follow mantissa");

	channel_frequency_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && channel_number == 8'h00 |=> operating_frequency == $past(base_frequency))
		else $error("channel zero is not the base frequency");

	fsk_deviation_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && !msk_mode && deviation_exponent == 3'h0
		|=> deviation_step == {7'h00, 1'b1, $past(deviation_mantissa)})
		else $error("fsk deviation wrong");

	msk_fraction_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && msk_mode |=> msk_phase_fraction == $past(deviation_mantissa) && deviation_step == 11'h000)
		else $error("msk fraction wrong");

endmodule // modem_freq_calc

//--- hw/modem_rx_defines.svh
`ifndef MODEM_RX_DEFINES_SVH
`define MODEM_RX_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_SPACING_EXPONENT    8'h13
`define REG_SPACING_MANTISSA    8'h14
`define REG_FREQ_DEVIATION      8'h15
`define REG_RX_TIMEOUT_CTRL     8'h16
`define REG_RX_STATUS           8'h20

// ****************************************************************
// Reset values
// ****************************************************************
`define SPACING_EXPONENT_RESET  2'h2
`define SPACING_MANTISSA_RESET  8'hF8
`define DEVIATION_EXP_RESET     3'h4
`define DEVIATION_MANT_RESET    3'h7
`define RX_TIME_RESET           3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define DEV_EXP_MSB             6
`define DEV_EXP_LSB             4
`define DEV_MANT_MSB            2
`define DEV_MANT_LSB            0
`define CTRL_CARRIER_BIT        4
`define CTRL_QUAL_BIT           3
`define CTRL_TIME_MSB           2
`define CTRL_TIME_LSB           0

// ****************************************************************
// Arithmetic and timing constants
// ****************************************************************
`define SPACING_IMPLIED_ONE     9'h100
`define DEVIATION_IMPLIED_ONE   4'h8
`define RX_TIME_NO_TIMEOUT      3'h7
`define TIMEOUT_BASE_SHIFT      3
`define OOK_CARRIER_SYMBOLS     4'h8
`define CLOCK_PERIOD_NS         20

`endif

//--- hw/modem_rx_pkg.sv
package modem_rx_pkg;

	typedef enum logic [1:0]
	{
		RX_IDLE   = 2'b00,
		RX_SEARCH = 2'b01,
		RX_HOLD   = 2'b10
	} rx_state_e;

	typedef logic [7:0] reg_byte_t;

endpackage

//--- hw/modem_rx_timeout_config.sv
`timescale 1ns/1ps
`include "modem_rx_defines.svh"

module modem_rx_timeout_config
	import modem_rx_pkg::*;
#(
	parameter int BASE_W = 24
)
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic [7:0]        address,
	input  wire logic [7:0]        write_data,
	input  wire logic              write_strobe,
	input  wire logic              read_strobe,
	output reg_byte_t              read_data,
	input  wire logic [7:0]        channel_number,
	input  wire logic [BASE_W-1:0] base_frequency,
	input  wire logic              msk_mode,
	input  wire logic              ook_mode,
	input  wire logic [15:0]       wake_event_zero,
	input  wire logic [1:0]        wake_resolution,
	input  wire logic              rc_clock_pin,
	input  wire logic              rx_start,
	input  wire logic              sync_found,
	input  wire logic              preamble_quality,
	input  wire logic              carrier_sense,
	input  wire logic              symbol_tick,
	input  wire logic              packet_end,
	output logic      [11:0]       channel_spacing,
	output logic      [BASE_W-1:0] operating_frequency,
	output logic      [10:0]       deviation_step,
	output logic      [2:0]        msk_phase_fraction,
	output logic                   rx_active,
	output logic                   rx_timeout,
	output logic                   rx_stay,
	output logic                   rx_carrier_end
);

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic [1:0]  spacing_exponent;
	logic [7:0]  spacing_mantissa;
	logic [2:0]  deviation_exponent;
	logic [2:0]  deviation_mantissa;
	logic        rx_end_on_carrier_loss;
	logic        rx_timeout_qualifier;
	logic [2:0]  timeout_setting;
	logic        timed_out_last;
	reg_byte_t   read_value;
	logic        any_write_seen;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			spacing_exponent       <= `SPACING_EXPONENT_RESET;
			spacing_mantissa       <= `SPACING_MANTISSA_RESET;
			deviation_exponent     <= `DEVIATION_EXP_RESET;
			deviation_mantissa     <= `DEVIATION_MANT_RESET;
			rx_end_on_carrier_loss <= 1'b0;
			rx_timeout_qualifier   <= 1'b0;
			timeout_setting        <= `RX_TIME_RESET;
		end
		else if (ce && write_strobe)
		begin
			// Only defined field bits are stored; the rest are dropped.
			case (address)
				`REG_SPACING_EXPONENT:
				begin
					spacing_exponent <= write_data[1:0];
				end
				`REG_SPACING_MANTISSA:
				begin
					spacing_mantissa <= write_data;
				end
				`REG_FREQ_DEVIATION:
				begin
					deviation_exponent <= write_data[`DEV_EXP_MSB:`DEV_EXP_LSB];
					deviation_mantissa <= write_data[`DEV_MANT_MSB:`DEV_MANT_LSB];
				end
				`REG_RX_TIMEOUT_CTRL:
				begin
					rx_end_on_carrier_loss <= write_data[`CTRL_CARRIER_BIT];
					rx_timeout_qualifier   <= write_data[`CTRL_QUAL_BIT];
					timeout_setting        <= write_data[`CTRL_TIME_MSB:`CTRL_TIME_LSB];
				end
				default:
				begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			any_write_seen <= 1'b0;
		end
		else if (ce && write_strobe)
		begin
			any_write_seen <= 1'b1;
		end
	end

	rx_state_e state;

	always_comb
	begin
		read_value = 8'h00;
		case (address)
			`REG_SPACING_EXPONENT: read_value = {6'h00, spacing_exponent};
			`REG_SPACING_MANTISSA: read_value = spacing_mantissa;
			`REG_FREQ_DEVIATION:   read_value = {1'b0, deviation_exponent, 1'b0, deviation_mantissa};
			`REG_RX_TIMEOUT_CTRL:  read_value = {3'h0, rx_end_on_carrier_loss,
				rx_timeout_qualifier, timeout_setting};
			`REG_RX_STATUS:        read_value = {5'h00, timed_out_last, state};
			default:               read_value = 8'h00;
		endcase
	end

	// Read data stand for exactly one cycle after the strobe.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			read_data <= 8'h00;
		end
		else if (ce)
		begin
			read_data <= read_strobe ? read_value : 8'h00;
		end
	end

	// ****************************************************************
	// Frequency and deviation
	// ****************************************************************
	modem_freq_calc #(.BASE_W(BASE_W)) freq_calc
	(
		.clock               (clock),
		.rst_b               (rst_b),
		.ce                  (ce),
		.spacing_mantissa    (spacing_mantissa),
		.spacing_exponent    (spacing_exponent),
		.channel_number      (channel_number),
		.base_frequency      (base_frequency),
		.deviation_exponent  (deviation_exponent),
		.deviation_mantissa  (deviation_mantissa),
		.msk_mode            (msk_mode),
		.channel_spacing     (channel_spacing),
		.operating_frequency (operating_frequency),
		.deviation_step      (deviation_step),
		.msk_phase_fraction  (msk_phase_fraction)
	);

	// ****************************************************************
	// Sync search timer
	// ****************************************************************
	logic        rc_tick;
	logic [2:0]  search_setting;
	logic [12:0] timeout_count;
	logic [12:0] timeout_load;
	logic [11:0] prescale_count;
	logic [11:0] unit_limit;
	logic        unit_done;
	logic        expire;
	logic        qualified;
	logic        sync_seen;
	logic        timer_armed;

	rc_tick_sync rc_sync
	(
		.clock        (clock),
		.rst_b        (rst_b),
		.ce           (ce),
		.rc_clock_pin (rc_clock_pin),
		.rc_tick      (rc_tick)
	);

	// One count unit is 2^(4*resolution) RC periods, giving the extra resolution divide.
	always_comb
	begin
		case (wake_resolution)
			2'h0:    unit_limit = 12'h000;
			2'h1:    unit_limit = 12'h00F;
			2'h2:    unit_limit = 12'h0FF;
			default: unit_limit = 12'hFFF;
		endcase
		timeout_load = 13'(wake_event_zero >> (`TIMEOUT_BASE_SHIFT + timeout_setting));
	end

	assign timer_armed = (search_setting != `RX_TIME_NO_TIMEOUT);
	assign unit_done   = (state == RX_SEARCH) && timer_armed && rc_tick
		&& (prescale_count == unit_limit);
	assign expire      = unit_done && (timeout_count <= 13'h0001);
	assign qualified   = sync_seen || sync_found
		|| (rx_timeout_qualifier && preamble_quality);

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			search_setting <= `RX_TIME_RESET;
			timeout_count  <= 13'h0000;
			prescale_count <= 12'h000;
		end
		else if (ce)
		begin
			if (state == RX_IDLE && rx_start)
			begin
				search_setting <= timeout_setting;
				timeout_count  <= timeout_load;
				prescale_count <= 12'h000;
			end
			else if (state == RX_SEARCH && timer_armed && rc_tick)
			begin
				if (prescale_count == unit_limit)
				begin
					prescale_count <= 12'h000;
					timeout_count  <= timeout_count - 13'h0001;
				end
				else
				begin
					prescale_count <= prescale_count + 12'h001;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_seen <= 1'b0;
		end
		else if (ce)
		begin
			if (state == RX_IDLE)
			begin
				sync_seen <= 1'b0;
			end
			else if (sync_found)
			begin
				sync_seen <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Carrier-sense termination
	// ****************************************************************
	logic [3:0] symbol_count;
	logic       carrier_seen;
	logic       ook_expire;
	logic       carrier_end;

	assign ook_expire  = rx_end_on_carrier_loss && ook_mode && (state == RX_SEARCH)
		&& !carrier_seen && !carrier_sense && symbol_tick
		&& (symbol_count == `OOK_CARRIER_SYMBOLS - 4'h1);
	assign carrier_end = rx_end_on_carrier_loss && !ook_mode && (state != RX_IDLE)
		&& !carrier_sense;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			symbol_count <= 4'h0;
			carrier_seen <= 1'b0;
		end
		else if (ce)
		begin
			if (state == RX_IDLE)
			begin
				symbol_count <= 4'h0;
				carrier_seen <= 1'b0;
			end
			else
			begin
				if (carrier_sense)
				begin
					carrier_seen <= 1'b1;
				end
				if (symbol_tick && symbol_count != `OOK_CARRIER_SYMBOLS)
				begin
					symbol_count <= symbol_count + 4'h1;
				end
			end
		end
	end

	// ****************************************************************
	// Receive state
	// ****************************************************************
	rx_state_e next_state;

	always_comb
	begin
		next_state = state;
		case (state)
			RX_IDLE:
			begin
				if (rx_start)
				begin
					next_state = RX_SEARCH;
				end
			end
			RX_SEARCH:
			begin
				if (carrier_end || ook_expire || packet_end)
				begin
					next_state = RX_IDLE;
				end
				else if (expire)
				begin
					next_state = qualified ? RX_HOLD : RX_IDLE;
				end
			end
			RX_HOLD:
			begin
				if (packet_end || carrier_end)
				begin
					next_state = RX_IDLE;
				end
			end
			default:
			begin
				next_state = RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state          <= RX_IDLE;
			rx_active      <= 1'b0;
			rx_timeout     <= 1'b0;
			rx_stay        <= 1'b0;
			rx_carrier_end <= 1'b0;
		end
		else if (ce)
		begin
			state          <= next_state;
			rx_active      <= (next_state != RX_IDLE);
			rx_timeout     <= (state == RX_SEARCH) && !carrier_end && !packet_end
				&& (ook_expire || (expire && !qualified));
			rx_stay        <= (state == RX_SEARCH) && !carrier_end && !ook_expire
				&& !packet_end && expire && qualified;
			rx_carrier_end <= carrier_end;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timed_out_last <= 1'b0;
		end
		else if (ce)
		begin
			if (next_state == RX_IDLE && !packet_end && !carrier_end && (ook_expire || expire))
			begin
				timed_out_last <= 1'b1;
			end
			else if (state == RX_IDLE && rx_start)
			begin
				timed_out_last <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	sequence search_expires_s;
		ce && state == RX_SEARCH && expire && !carrier_end && !packet_end && !ook_expire;
	endsequence

	reset_values_a: assert property (@(posedge clock) disable iff (!rst_b)
		!any_write_seen |-> spacing_mantissa == 8'hF8 && deviation_exponent == 3'h4
			&& deviation_mantissa == 3'h7 && timeout_setting == 3'h7
			&& !rx_timeout_qualifier && !rx_end_on_carrier_loss)
		else $error("reset value lost");

	reserved_zero_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && read_strobe && address == 8'h15 |=> read_data[7] == 1'b0 && read_data[3] == 1'b0)
		else $error("reserved deviation bits not zero");

	exponent_field_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && write_strobe && address == 8'h13 |=> spacing_exponent == $past(write_data[1:0]))
		else $error("spacing exponent not stored");

	timeout_drop_a: assert property (@(posedge clock) disable iff (!rst_b)
		search_expires_s and !qualified |=> rx_timeout && state == RX_IDLE)
		else $error("unqualified expiry did not time out");

	timeout_stay_a: assert property (@(posedge clock) disable iff (!rst_b)
		search_expires_s and qualified |=> rx_stay && !rx_timeout && state == RX_HOLD)
		else $error("qualified expiry did not stay");

	no_timeout_a: assert property (@(posedge clock) disable iff (!rst_b)
		state == RX_SEARCH && search_setting == 3'h7 && !ook_expire |=> !rx_timeout)
		else $error("timeout under setting seven");

	count_load_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && state == RX_IDLE && rx_start && timeout_setting == 3'h6
		|=> timeout_count == {6'h00, $past(wake_event_zero[15:9])})
		else $error("timeout count load wrong");

	ook_symbols_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && ook_expire && !packet_end |=> rx_timeout && !rx_active ##0 $past(symbol_count) == 4'h7)
		else $error("ook carrier timeout wrong");

	carrier_stop_a: assert property (@(posedge clock) disable iff (!rst_b)
		ce && carrier_end |=> rx_carrier_end && state == RX_IDLE)
		else $error("carrier loss did not end reception");

endmodule // modem_rx_timeout_config

//--- hw/rc_tick_sync.sv
`timescale 1ns/1ps

// Brings the free-running RC oscillator into the clock domain as a one-cycle tick.
module rc_tick_sync
(
	input  wire logic clock,
	input  wire logic rst_b,
	input  wire logic ce,
	input  wire logic rc_clock_pin,
	output logic      rc_tick
);

	logic stage_one;
	logic stage_two;
	logic stage_three;
	logic settled;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage_one   <= 1'b0;
			stage_two   <= 1'b0;
			stage_three <= 1'b0;
		end
		else if (ce)
		begin
			stage_one   <= rc_clock_pin;
			stage_two   <= stage_one;
			stage_three <= stage_two;
		end
	end

	// A change is accepted only once the last two stages agree.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			settled <= 1'b0;
			rc_tick <= 1'b0;
		end
		else if (ce)
		begin
			if (stage_two == stage_three)
			begin
				settled <= stage_three;
			end
			rc_tick <= (stage_two == stage_three) && stage_three && !settled;
		end
	end

endmodule // rc_tick_sync
